// File: rtl/asq_pkg.sv
// Purpose: shared constants and carrier types for the static memory access sequencer
// Assumes: 200 MHz clock, 55 ns speed grade timing figures
// Notes:   times in ns, cycle counts derived from them
package asq_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 16;
    // timing figures as printed (ns)
    localparam int READ_CYCLE_TIME_NS        = 55;
    localparam int ADDR_ACCESS_NS            = 55;
    localparam int WRITE_PULSE_WIDTH_NS      = 40;
    localparam int WRITE_CYCLE_NS            = 55;
    localparam int WRITE_TO_FLOAT_DELAY_NS   = 20;
    localparam int OE_RELEASE_TO_FLOAT_NS    = 20;
    localparam int DATA_SETUP_NS             = 25;
    localparam int WRITE_ADDR_SETUP_NS       = 0;
    localparam int RETENTION_SETUP_TIME_NS   = 0;
    localparam int RETENTION_RECOVERY_NS     = READ_CYCLE_TIME_NS;
    // least times round up
    localparam int RC_CYC   = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AA_CYC   = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWE_CYC  = (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC   = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZOE_CYC = (OE_RELEASE_TO_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZWE_CYC = (WRITE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RDR_CYC  = (RETENTION_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W    = 5;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

    typedef enum logic [1:0]
    {
        ASQ_WR_WE_OE_HI  = 2'h0,   // write-enable bounded, output enable high
        ASQ_WR_WE_OE_LO  = 2'h1,   // write-enable bounded, output enable low
        ASQ_WR_SEL       = 2'h2,   // chip-select pair bounded
        ASQ_WR_BYTE      = 2'h3    // byte-enable bounded
    } asq_wmode_t;

    typedef enum logic [2:0]
    {
        ASQ_ST_RESET  = 3'h0,
        ASQ_ST_IDLE   = 3'h1,
        ASQ_ST_READ   = 3'h2,
        ASQ_ST_WFLOAT = 3'h3,
        ASQ_ST_WRITE  = 3'h4,
        ASQ_ST_WEND   = 3'h5,
        ASQ_ST_RETAIN = 3'h6,
        ASQ_ST_RECOV  = 3'h7
    } asq_state_t;

    typedef struct packed
    {
        logic              write;
        asq_wmode_t        wmode;
        logic [1:0]        byte_en;    // bit1 upper, bit0 lower, active high
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asq_req_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic              select_low_n;
        logic              select_high;
        logic              oe_n;
        logic              we_n;
        logic              upper_byte_enable_n;
        logic              lower_byte_enable_n;
    } asq_pins_t;

    localparam asq_pins_t PINS_IDLE = '{addr: '0, select_low_n: 1'b1, select_high: 1'b0, oe_n: 1'b1,
                                        we_n: 1'b1, upper_byte_enable_n: 1'b1, lower_byte_enable_n: 1'b1};
endpackage : asq_pkg

// File: rtl/asq_ctrl.sv
// Purpose: host controller sequencing reads, four write forms and retention for an async static memory
// Assumes: one clock domain; memory is clockless and driven only through its pins
// Notes:   one request at a time; data bus output enable is low while driving
// Functional notes
// (R1) memory presents read data while held selected
// (R2) address valid before select becomes true; code drives address and select on the same edge
// (R3) select pair may bound a write
// (R4) data drivers off while memory still drives
// (R5) memory floats after output enable release
// (R6) oe low write: wait write float delay
// (R7) prefer output enable high during writes
// (R8) byte-bounded write keeps write enable low
// (R9) float interval skipped when oe released first; code still waits HZOE_CYC in the three forms other than oe-low
// (R10) retention by deselecting or dropping byte enables
// (R11) write enable may bound write, oe high
// (R12) write only while all four conditions hold
// (R13) wait read cycle after retention exit
`timescale 1ns/1ps
module asq_ctrl
    import asq_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire logic              req_valid_i,
    input  wire asq_req_t          req_i,
    output logic                   req_ready_o,
    input  wire logic              retain_i,
    output logic                   retained_o,
    output logic                   rd_valid_o,
    output logic [DATA_W-1:0]      rd_data_o,
    output asq_pins_t              pins_o,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0]      dq_o,
    output logic                   dq_oe_n_o
);
    asq_state_t         state_q, state_d;
    logic [CNT_W-1:0]   cnt_q, cnt_d;
    asq_req_t           req_q, req_d;
    asq_pins_t          pins_q, pins_d;
    logic               dq_oe_n_q, dq_oe_n_d;
    logic [DATA_W-1:0]  rd_data_q, rd_data_d;
    logic               rd_valid_q, rd_valid_d;
    logic [DATA_W-1:0]  dq_s1_q, dq_s2_q;

    // read data path synchroniser, two stages before use
    always_ff @(posedge clock_i)
    begin
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
    end

    always_comb
    begin
        state_d    = state_q;
        cnt_d      = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - CNT_ONE;
        req_d      = req_q;
        pins_d     = pins_q;
        dq_oe_n_d  = dq_oe_n_q;
        rd_data_d  = rd_data_q;
        rd_valid_d = 1'b0;
        case (state_q)
            ASQ_ST_RESET:
            begin
                pins_d    = PINS_IDLE;
                dq_oe_n_d = 1'b1;
                state_d   = ASQ_ST_IDLE;
            end
            ASQ_ST_IDLE:
            begin
                if (retain_i)
                begin
                    // zero setup: deselect immediately; select high low alone suffices
                    pins_d             = PINS_IDLE; // R10
                    state_d            = ASQ_ST_RETAIN; // R13
                end
                else if (req_valid_i)
                begin
                    req_d              = req_i;
                    // address goes out with, never after, the selecting edge
                    pins_d.addr        = req_i.addr; // R2
                    pins_d.select_low_n = 1'b0;
                    pins_d.select_high = (req_i.write && req_i.wmode == ASQ_WR_SEL) ? 1'b0 : 1'b1;
                    pins_d.upper_byte_enable_n = ~(req_i.write ? req_i.byte_en[1] : 1'b1);
                    pins_d.lower_byte_enable_n = ~(req_i.write ? req_i.byte_en[0] : 1'b1);
                    if (req_i.write && req_i.wmode == ASQ_WR_BYTE)
                    begin
                        pins_d.upper_byte_enable_n = 1'b1;
                        pins_d.lower_byte_enable_n = 1'b1;
                    end
                    if (!req_i.write)
                    begin
                        pins_d.oe_n = 1'b0; // R1
                        pins_d.we_n = 1'b1;
                        cnt_d       = CNT_W'(RC_CYC);
                        state_d     = ASQ_ST_READ;
                    end
                    else
                    begin
                        // only the oe-low form keeps output enable active; others release it first
                        pins_d.oe_n = (req_i.wmode == ASQ_WR_WE_OE_LO) ? 1'b0 : 1'b1; // R7 R11
                        pins_d.we_n = (req_i.wmode == ASQ_WR_WE_OE_HI || req_i.wmode == ASQ_WR_WE_OE_LO)
                                      ? 1'b1 : 1'b0; // R8
                        // one extra count: write enable only falls on the next edge
                        cnt_d       = (req_i.wmode == ASQ_WR_WE_OE_LO) ? CNT_W'(HZWE_CYC) + CNT_ONE
                                      : CNT_W'(HZOE_CYC); // R5 R6 R9
                        state_d     = ASQ_ST_WFLOAT;
                    end
                end
            end
            ASQ_ST_READ:
            begin
                if (cnt_q == CNT_ONE)
                begin
                    // sample late; two sync stages already cover pin settling
                    rd_data_d  = dq_s2_q;
                    rd_valid_d = 1'b1;
                    pins_d     = PINS_IDLE;
                    pins_d.addr = req_q.addr;
                    state_d    = ASQ_ST_IDLE;
                end
            end
            ASQ_ST_WFLOAT:
            begin
                // bus stays undriven until memory outputs have floated
                if (req_q.wmode == ASQ_WR_WE_OE_LO && pins_q.we_n)
                begin
                    pins_d.we_n = 1'b0; // R6
                end
                if (cnt_q == CNT_ONE)
                begin
                    dq_oe_n_d = 1'b0; // R4 R6
                    pins_d.we_n = 1'b0;
                    pins_d.select_low_n = 1'b0;
                    pins_d.select_high  = 1'b1; // R3
                    pins_d.upper_byte_enable_n = ~req_q.byte_en[1];
                    pins_d.lower_byte_enable_n = ~req_q.byte_en[0];
                    cnt_d   = CNT_W'(PWE_CYC);
                    state_d = ASQ_ST_WRITE;
                end
            end
            ASQ_ST_WRITE:
            begin
                if (cnt_q == CNT_ONE)
                begin
                    // terminate with the bounding strobe of the chosen form
                    case (req_q.wmode)
                        ASQ_WR_SEL:  pins_d.select_high = 1'b0; // R3 R12
                        ASQ_WR_BYTE:
                        begin
                            pins_d.upper_byte_enable_n = 1'b1; // R12
                            pins_d.lower_byte_enable_n = 1'b1;
                        end
                        default:
                        begin
                            // release oe too, else the memory re-drives into our data hold
                            pins_d.we_n = 1'b1; // R11 R12
                            pins_d.oe_n = 1'b1; // R6
                        end
                    endcase
                    cnt_d   = CNT_W'(WC_CYC - PWE_CYC);
                    state_d = ASQ_ST_WEND;
                end
            end
            ASQ_ST_WEND:
            begin
                // data and address held one cycle past write end (zero hold)
                dq_oe_n_d = 1'b1;
                pins_d    = PINS_IDLE;
                pins_d.addr = req_q.addr;
                if (cnt_q <= CNT_ONE)
                begin
                    state_d = ASQ_ST_IDLE;
                end
            end
            ASQ_ST_RETAIN:
            begin
                if (!retain_i)
                begin
                    cnt_d   = CNT_W'(RDR_CYC); // R13
                    state_d = ASQ_ST_RECOV;
                end
            end
            ASQ_ST_RECOV:
            begin
                if (cnt_q == CNT_ONE)
                begin
                    state_d = ASQ_ST_IDLE; // R13
                end
            end
            default:
            begin
                state_d = ASQ_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            state_q    <= ASQ_ST_RESET;
            cnt_q      <= CNT_ZERO;
            req_q      <= '0;
            pins_q     <= PINS_IDLE;
            dq_oe_n_q  <= 1'b1;
            rd_data_q  <= '0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            req_q      <= req_d;
            pins_q     <= pins_d;
            dq_oe_n_q  <= dq_oe_n_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign req_ready_o = (state_q == ASQ_ST_IDLE) && !retain_i;
    assign retained_o  = (state_q == ASQ_ST_RETAIN);
    assign rd_valid_o  = rd_valid_q;
    assign rd_data_o   = rd_data_q;
    assign pins_o      = pins_q;
    assign dq_o        = req_q.wdata;
    assign dq_oe_n_o   = dq_oe_n_q;
endmodule : asq_ctrl

// File: test/asq_ctrl_monitor.sv
// Purpose: port checks for asq_ctrl
// Assumes: one clock, sync active-low reset
// Notes: cycle counts written as literals, only PINS_IDLE from package
`timescale 1ns/1ps
module asq_ctrl_monitor
    import asq_pkg::*;
(
    input wire logic      clock_i,
    input wire logic      rst_b_i,
    input wire logic      req_valid_i,
    input wire asq_req_t  req_i,
    input wire logic      req_ready_o,
    input wire logic      retained_o,
    input wire logic      rd_valid_o,
    input wire asq_pins_t pins_o,
    input wire logic      dq_oe_n_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    wire logic sel = !pins_o.select_low_n && pins_o.select_high;
    sequence s_take_rd; req_valid_i && req_ready_o && !req_i.write; endsequence
    sequence s_take_wr; req_valid_i && req_ready_o && req_i.write; endsequence
    a_reset_idle: assert property (disable iff (1'b0) !rst_b_i |=> pins_o == PINS_IDLE && dq_oe_n_o && !rd_valid_o)
        else $error("pins not idle after reset");
    a_read_answer: assert property (s_take_rd |-> ##12 rd_valid_o)
        else $error("read answer late");
    a_write_done: assert property (s_take_wr |=> !req_ready_o [*8] ##[1:16] req_ready_o)
        else $error("write length wrong");
    a_rd_pulse: assert property (rd_valid_o |=> !rd_valid_o)
        else $error("read valid too long");
    a_addr_held: assert property (sel && $past(sel) |-> $stable(pins_o.addr))
        else $error("address moved while selected");
    a_no_contend: assert property (!dq_oe_n_o |-> !(sel && !pins_o.oe_n && pins_o.we_n))
        else $error("drive while memory reads");
    a_float_wait: assert property (!dq_oe_n_o && !pins_o.oe_n && sel |-> !$past(pins_o.we_n, 4))
        else $error("drive before float delay");
    a_retain_off: assert property (retained_o |-> !sel || (pins_o.upper_byte_enable_n && pins_o.lower_byte_enable_n))
        else $error("retention while selected");
    a_recover_wait: assert property ($fell(retained_o) |-> !req_ready_o [*8])
        else $error("access too soon after retention");
endmodule : asq_ctrl_monitor
bind asq_ctrl asq_ctrl_monitor u_mon (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .retained_o(retained_o), .rd_valid_o(rd_valid_o), .pins_o(pins_o), .dq_oe_n_o(dq_oe_n_o));

// File: test/asq_mem_model.sv
// Purpose: behavioural static memory
// Assumes: sampled on the bench clock
// Notes: released bus shows inverse of last value
`timescale 1ns/1ps
module asq_mem_model
    import asq_pkg::*;
(
    input  wire logic              clock_i,
    input  wire asq_pins_t         pins_i,
    input  wire logic [DATA_W-1:0] dq_i,
    input  wire logic              dq_oe_n_i,
    output logic [DATA_W-1:0]      dq_o,
    output int                     clash_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last;
    int                wcnt;
    logic              sel;
    logic              drv;
    initial {last, wcnt, clash_o} = '0;
    assign sel = !pins_i.select_low_n && pins_i.select_high
                 && !(pins_i.upper_byte_enable_n && pins_i.lower_byte_enable_n);
    assign drv = sel && !pins_i.oe_n && (pins_i.we_n || wcnt < HZWE_CYC);
    assign dq_o = drv ? mem[pins_i.addr] : ~last;
    always @(posedge clock_i)
    begin
        last <= dq_o;
        wcnt <= (pins_i.we_n || pins_i.oe_n) ? 0 : wcnt + 1;
        if (drv && !dq_oe_n_i)
            clash_o <= clash_o + 1;
        if (sel && !pins_i.we_n && !dq_oe_n_i)
        begin
            if (!pins_i.upper_byte_enable_n)
                mem[pins_i.addr][15:8] = dq_i[15:8];
            if (!pins_i.lower_byte_enable_n)
                mem[pins_i.addr][7:0] = dq_i[7:0];
        end
    end
endmodule : asq_mem_model

// File: test/async_sram_access_sequencing_tb.sv
// Purpose: self-checking bench for asq_ctrl
// Assumes: 200 MHz clock
// Notes: inputs change at falling edge
`timescale 1ns/1ps
module async_sram_access_sequencing_tb;
    import asq_pkg::*;
    logic clock_i = 0, rst_b_i = 0, req_valid_i = 0, retain_i = 0;
    asq_req_t req_i = '0;
    logic req_ready_o, retained_o, rd_valid_o, dq_oe_n_o;
    logic [DATA_W-1:0] rd_data_o, dq_o, mem_dq, dq_bus;
    asq_pins_t pins_o;
    int failures = 0, checks = 0, clash;
    always #2.5 clock_i = ~clock_i;
    assign dq_bus = dq_oe_n_o ? mem_dq : dq_o;
    asq_ctrl uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .retain_i(retain_i), .retained_o(retained_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .pins_o(pins_o), .dq_i(dq_bus), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
    asq_mem_model mem (.clock_i(clock_i), .pins_i(pins_o), .dq_i(dq_bus), .dq_oe_n_i(dq_oe_n_o),
        .dq_o(mem_dq), .clash_o(clash));
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic issue(input asq_req_t r);
        int i;
        @(negedge clock_i);
        req_valid_i = 1;
        req_i = r;
        for (i = 0; i < 60 && req_ready_o !== 1'b1; i++) @(negedge clock_i);
        @(negedge clock_i);
        req_valid_i = 0;
    endtask : issue
    task automatic wr(input asq_wmode_t m, input logic [1:0] be, input logic [19:0] a, input logic [15:0] d);
        issue('{write: 1'b1, wmode: m, byte_en: be, addr: a, wdata: d});
    endtask : wr
    task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp);
        int i;
        issue('{write: 1'b0, wmode: ASQ_WR_WE_OE_HI, byte_en: 2'h3, addr: a, wdata: 16'h0000});
        for (i = 0; i < 40 && rd_valid_o !== 1'b1; i++) @(negedge clock_i);
        check(rd_valid_o === 1'b1 && rd_data_o === exp, "read data wrong");
    endtask : rd_chk
    task automatic t_modes;
        for (int k = 0; k < 4; k++)
            wr(asq_wmode_t'(k), 2'h3, 20'h00010 + 20'(k), 16'ha500 + 16'(k));
        for (int k = 0; k < 4; k++)
            rd_chk(20'h00010 + 20'(k), 16'ha500 + 16'(k));
    endtask : t_modes
    task automatic t_bytes;
        wr(ASQ_WR_BYTE, 2'h3, 20'hfffff, 16'h1234);
        wr(ASQ_WR_WE_OE_LO, 2'h1, 20'hfffff, 16'habcd);
        wr(ASQ_WR_SEL, 2'h2, 20'hfffff, 16'hff00);
        wr(ASQ_WR_WE_OE_HI, 2'h0, 20'hfffff, 16'h5555);
        rd_chk(20'hfffff, 16'hffcd);
    endtask : t_bytes
    task automatic t_retain;
        int n;
        @(negedge clock_i);
        retain_i = 1;
        repeat (4) @(negedge clock_i);
        check(retained_o === 1'b1 && req_ready_o === 1'b0 && pins_o.select_low_n === 1'b1, "no retention");
        retain_i = 0;
        for (n = 0; n < 40 && req_ready_o !== 1'b1; n++) @(negedge clock_i);
        check(n >= RDR_CYC - 1 && n < 40, "recovery length wrong");
        rd_chk(20'h00011, 16'ha501);
    endtask : t_retain
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        #200000;
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (6) @(negedge clock_i);
        check(pins_o === PINS_IDLE && dq_oe_n_o === 1'b1, "not idle in reset");
        rst_b_i = 1;
        t_modes();
        t_bytes();
        t_retain();
        check(clash == 0, "bus contention seen");
        give_verdict();
    end
endmodule : async_sram_access_sequencing_tb
